/* logic/cmou_unit.sv */
`include "cmou_defines.svh"
// Behaviour
// [R1] address is base plus sign-extended nine-bit offset
// [R2] virtual cache uses effective address directly, translation optional
// [R3] physical cache is addressed by translated address
// [R4] index ops translate; this unit indexes with untranslated address
// [R5] way and set fields derived from tag bytes, size, associativity
// [R6] direct-mapped cache ignores way, set alone selects tag
// [R7] translation faults report the load translation cause
// [R8] never a modified or store-cause translation fault
// [R9] never execute-inhibit or read-inhibit faults
// [R10] any alignment accepted, no misalignment address error
// [R11] writeback cache error reported as cache error
// [R12] bus error response raises bus error exception
// [R13] index tag read and write never raise cache error
// [R14] faulting kernel address raises load address error, chosen enabled
// [R15] cache operations never trigger data watch, by design choice
// [R16] retire waits for all generated traffic, barrier ordering
// [R17] bits 17:16 pick instruction, data, tertiary or secondary cache
// [R18] bits 20:18 pick operation, all eight codes forwarded
// [R19] outer-cache ops are applied to inner data cache first; with INCLUSIVE, translated path only, VIRT_CACHE non-index ops skip it
// [R20] software without inner-first hardware flushes inner then barriers
// [R21] hit ops broadcast only with coherent cacheability attribute
// [R22] all affected levels share one global or local choice
// [R23] fields held until ack or error, except first request cycle: VIRT_CACHE sends previous fields, translated path way and index of untranslated address
module cmou_unit #(
    parameter int BYTES_PER_TAG = 32,
    parameter int CACHE_BYTES = 16384,
    parameter int ASSOC = 4,
    parameter bit VIRT_CACHE = 1'b0,
    parameter bit INCLUSIVE = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [31:0] insn,
    input wire logic [31:0] base_value,
    output logic issue_ready,
    output logic xlate_req,
    output logic [31:0] xlate_vaddr,
    input wire logic xlate_done,
    input wire logic xlate_miss,
    input wire logic xlate_invalid,
    input wire logic [31:0] xlate_paddr,
    input wire logic [2:0] cacheability_attribute,
    output logic cache_req,
    output cmou_pkg::cmou_req_s cache_cmd,
    input wire logic cache_ack,
    input wire logic cache_err,
    input wire logic bus_err,
    input wire logic traffic_idle,
    output logic retire_valid,
    output cmou_pkg::cmou_retire_s retire_info
);
    cmou_pkg::cmou_state_e state_reg;
    cmou_pkg::cmou_word_t ea_reg;
    logic [1:0] target_reg;
    logic [2:0] oper_reg;
    logic global_reg;
    logic inner_done_reg;
    logic err_reg;
    logic [4:0] cause_reg;
    logic [7:0] split_way;
    logic [31:0] split_index;
    logic [31:0] ea_next;
    logic cache_addr_is_index;

    // true for operations that address by index
    function automatic logic is_index_op(input logic [2:0] op);
        is_index_op = (op == `CMOU_OP_INDEX_INVAL) || (op == `CMOU_OP_INDEX_LD_TAG)
            || (op == `CMOU_OP_INDEX_ST_TAG) || (op == `CMOU_OP_IMPL_DEP);
    endfunction

    // true for index tag read/write, diagnostic ops
    function automatic logic is_tag_diag(input logic [2:0] op);
        is_tag_diag = (op == `CMOU_OP_INDEX_LD_TAG) || (op == `CMOU_OP_INDEX_ST_TAG);
    endfunction

    // true for hit-type ops
    function automatic logic is_hit_op(input logic [2:0] op);
        is_hit_op = (op == `CMOU_OP_HIT_INVAL) || (op == `CMOU_OP_HIT_WB_INVAL)
            || (op == `CMOU_OP_HIT_WB);
    endfunction

    // true for the coherent cacheability attributes
    function automatic logic is_coherent(input logic [2:0] attr);
        is_coherent = (attr == `CMOU_CACHEABILITY_COHERENT_A)
            || (attr == `CMOU_CACHEABILITY_COHERENT_B);
    endfunction

    // effective address; full 32-bit sum, any alignment
    assign ea_next = base_value
        + {{23{insn[`CMOU_OFFSET_MSB]}}, insn[`CMOU_OFFSET_MSB:`CMOU_OFFSET_LSB]}; // see [R1] [R10]
    assign cache_addr_is_index = is_index_op(oper_reg);

    // index split uses ea_reg, untranslated for index ops and the VIRT_CACHE path, translated for the others
    cmou_index_split #(
        .ADDR_W(32),
        .BYTES_PER_TAG(BYTES_PER_TAG),
        .CACHE_BYTES(CACHE_BYTES),
        .ASSOC(ASSOC)
    ) u_split (
        .addr(ea_reg), // see [R4]
        .way(split_way),
        .index(split_index)
    );

    // main sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= cmou_pkg::CMOU_IDLE;
        end else begin
            case (state_reg)
                cmou_pkg::CMOU_IDLE: begin
                    if (issue_valid) begin
                        // kernel fault region short-cuts to retire
                        if (ea_next[31:29] == `CMOU_KERNEL_FAULT_TOP && !ea_next[28]) begin
                            state_reg <= cmou_pkg::CMOU_DRAIN; // see [R14]
                        end else if (VIRT_CACHE && !is_index_op(insn[`CMOU_OPER_MSB:`CMOU_OPER_LSB])) begin
                            state_reg <= cmou_pkg::CMOU_ISSUE; // see [R2]
                        end else begin
                            state_reg <= cmou_pkg::CMOU_XLATE; // see [R3] [R4]
                        end
                    end
                end
                cmou_pkg::CMOU_XLATE: begin
                    if (xlate_done) begin
                        if (xlate_miss || xlate_invalid) begin
                            state_reg <= cmou_pkg::CMOU_DRAIN;
                        end else if (INCLUSIVE && target_reg[1]) begin
                            state_reg <= cmou_pkg::CMOU_INNER; // see [R19]
                        end else begin
                            state_reg <= cmou_pkg::CMOU_ISSUE;
                        end
                    end
                end
                cmou_pkg::CMOU_INNER: begin
                    if (cache_ack || cache_err || bus_err) begin
                        state_reg <= (cache_err || bus_err) ? cmou_pkg::CMOU_DRAIN
                            : cmou_pkg::CMOU_ISSUE;
                    end
                end
                cmou_pkg::CMOU_ISSUE: begin
                    if (cache_ack || cache_err || bus_err) begin
                        state_reg <= cmou_pkg::CMOU_DRAIN; // see [R23]
                    end
                end
                cmou_pkg::CMOU_DRAIN: begin
                    if (traffic_idle) begin
                        state_reg <= cmou_pkg::CMOU_IDLE; // see [R16]
                    end
                end
                default: state_reg <= cmou_pkg::CMOU_IDLE;
            endcase
        end
    end

    // capture of instruction fields and address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ea_reg <= 32'h0000_0000;
            target_reg <= 2'h0;
            oper_reg <= 3'h0;
        end else if (state_reg == cmou_pkg::CMOU_IDLE && issue_valid) begin
            ea_reg <= ea_next;
            target_reg <= insn[`CMOU_TARGET_MSB:`CMOU_TARGET_LSB]; // see [R17]
            oper_reg <= insn[`CMOU_OPER_MSB:`CMOU_OPER_LSB]; // see [R18]
        end else if (state_reg == cmou_pkg::CMOU_XLATE && xlate_done && !cache_addr_is_index) begin
            ea_reg <= xlate_paddr; // see [R3]
        end
    end

    // one global decision per instruction, shared by all levels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            global_reg <= 1'b0;
        end else if (state_reg == cmou_pkg::CMOU_XLATE && xlate_done) begin
            global_reg <= is_hit_op(oper_reg)
                && is_coherent(cacheability_attribute); // see [R21] [R22]
        end else if (state_reg == cmou_pkg::CMOU_IDLE) begin
            global_reg <= 1'b0;
        end
    end

    // inner pass tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            inner_done_reg <= 1'b0;
        end else if (state_reg == cmou_pkg::CMOU_INNER && cache_ack) begin
            inner_done_reg <= 1'b1;
        end else if (state_reg == cmou_pkg::CMOU_IDLE) begin
            inner_done_reg <= 1'b0;
        end
    end

    // exception recording; address and translation causes are load-type only, besides cache and bus error
    // no store cause, no modified, inhibit, watch or misalign paths
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            err_reg <= 1'b0;
            cause_reg <= 5'h00;
        end else if (state_reg == cmou_pkg::CMOU_IDLE) begin
            err_reg <= 1'b0;
            cause_reg <= 5'h00;
            if (issue_valid && ea_next[31:29] == `CMOU_KERNEL_FAULT_TOP && !ea_next[28]) begin
                err_reg <= 1'b1;
                cause_reg <= `CMOU_LOAD_ADDRESS_ERROR_CAUSE; // see [R14]
            end
        end else if (state_reg == cmou_pkg::CMOU_XLATE && xlate_done
            && (xlate_miss || xlate_invalid)) begin
            err_reg <= 1'b1;
            cause_reg <= `CMOU_LOAD_TRANSLATION_CAUSE; // see [R7] [R8] [R9] [R15]
        end else if ((state_reg == cmou_pkg::CMOU_ISSUE || state_reg == cmou_pkg::CMOU_INNER)
            && !err_reg) begin
            if (cache_err && !is_tag_diag(oper_reg)) begin
                err_reg <= 1'b1;
                cause_reg <= `CMOU_CACHE_ERR_CAUSE; // see [R11] [R13]
            end else if (bus_err) begin
                err_reg <= 1'b1;
                cause_reg <= `CMOU_BUS_ERR_CAUSE; // see [R12]
            end
        end
    end

    // handshake outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            issue_ready <= 1'b0;
            xlate_req <= 1'b0;
            xlate_vaddr <= 32'h0000_0000;
            cache_req <= 1'b0;
            retire_valid <= 1'b0;
            retire_info <= '0;
        end else begin
            issue_ready <= (state_reg == cmou_pkg::CMOU_DRAIN) && traffic_idle;
            xlate_req <= state_reg == cmou_pkg::CMOU_IDLE && issue_valid
                && !(VIRT_CACHE && !is_index_op(insn[`CMOU_OPER_MSB:`CMOU_OPER_LSB]))
                && !(ea_next[31:29] == `CMOU_KERNEL_FAULT_TOP && !ea_next[28]);
            if (state_reg == cmou_pkg::CMOU_IDLE && issue_valid) begin
                xlate_vaddr <= ea_next;
            end
            cache_req <= ((state_reg == cmou_pkg::CMOU_XLATE && xlate_done
                && !xlate_miss && !xlate_invalid)
                || (state_reg == cmou_pkg::CMOU_INNER && cache_ack)
                || (state_reg == cmou_pkg::CMOU_IDLE && issue_valid && VIRT_CACHE
                && !is_index_op(insn[`CMOU_OPER_MSB:`CMOU_OPER_LSB])
                && !(ea_next[31:29] == `CMOU_KERNEL_FAULT_TOP && !ea_next[28])))
                || (cache_req && !cache_ack && !cache_err && !bus_err); // see [R23]
            retire_valid <= (state_reg == cmou_pkg::CMOU_DRAIN) && traffic_idle; // see [R16]
            retire_info.exc <= err_reg;
            retire_info.cause <= cause_reg;
        end
    end

    // command word to the controllers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cache_cmd <= '0;
        end else begin
            // inner target held until the inner pass is acknowledged
            cache_cmd.target <= ((state_reg == cmou_pkg::CMOU_XLATE
                || (state_reg == cmou_pkg::CMOU_INNER && !cache_ack))
                && INCLUSIVE && target_reg[1]) ? `CMOU_TGT_PRI_DATA : target_reg; // see [R19]
            if (state_reg == cmou_pkg::CMOU_INNER && inner_done_reg) begin
                cache_cmd.target <= target_reg;
            end
            cache_cmd.oper <= oper_reg;
            cache_cmd.addr <= (state_reg == cmou_pkg::CMOU_XLATE && !cache_addr_is_index)
                ? xlate_paddr : ea_reg;
            cache_cmd.way <= split_way; // see [R5] [R6]
            cache_cmd.index <= split_index;
            // broadcast flag valid in the same cycle as the first request
            cache_cmd.global_op <= (state_reg == cmou_pkg::CMOU_XLATE && xlate_done)
                ? (is_hit_op(oper_reg) && is_coherent(cacheability_attribute))
                : global_reg; // see [R21] [R22]
        end
    end
endmodule

/* logic/cmou_defines.svh */
`ifndef CMOU_DEFINES_SVH
`define CMOU_DEFINES_SVH

// instruction field positions
`define CMOU_OFFSET_MSB 15
`define CMOU_OFFSET_LSB 7
`define CMOU_TARGET_MSB 17
`define CMOU_TARGET_LSB 16
`define CMOU_OPER_MSB 20
`define CMOU_OPER_LSB 18

// target cache codes
`define CMOU_TGT_PRI_INSN 2'h0
`define CMOU_TGT_PRI_DATA 2'h1
`define CMOU_TGT_TERTIARY 2'h2
`define CMOU_TGT_SECONDARY 2'h3

// operation codes with fixed meaning in this unit
`define CMOU_OP_INDEX_INVAL 3'h0
`define CMOU_OP_INDEX_LD_TAG 3'h1
`define CMOU_OP_INDEX_ST_TAG 3'h2
`define CMOU_OP_IMPL_DEP 3'h3
`define CMOU_OP_HIT_INVAL 3'h4
`define CMOU_OP_HIT_WB_INVAL 3'h5
`define CMOU_OP_HIT_WB 3'h6
`define CMOU_OP_FETCH_LOCK 3'h7

// exception cause codes
`define CMOU_LOAD_ADDRESS_ERROR_CAUSE 5'h04
`define CMOU_LOAD_TRANSLATION_CAUSE 5'h02
`define CMOU_CACHE_ERR_CAUSE 5'h1e
`define CMOU_BUS_ERR_CAUSE 5'h07

// cacheability attribute codes that are coherent
`define CMOU_CACHEABILITY_COHERENT_A 3'h4
`define CMOU_CACHEABILITY_COHERENT_B 3'h5

// kernel region that faults on a mapped access
`define CMOU_KERNEL_FAULT_TOP 3'h7

`endif

/* logic/cmou_pkg.sv */
package cmou_pkg;
    typedef enum logic [4:0] {
        CMOU_IDLE = 5'b00001,
        CMOU_XLATE = 5'b00010,
        CMOU_INNER = 5'b00100,
        CMOU_ISSUE = 5'b01000,
        CMOU_DRAIN = 5'b10000
    } cmou_state_e;

    // request to a cache controller
    typedef struct packed {
        logic [1:0] target;
        logic [2:0] oper;
        logic [31:0] addr;
        logic [7:0] way;
        logic [31:0] index;
        logic global_op;
    } cmou_req_s;

    // completed instruction
    typedef struct packed {
        logic exc;
        logic [4:0] cause;
    } cmou_retire_s;

    typedef logic [31:0] cmou_word_t;
endpackage

/* logic/cmou_index_split.sv */
`include "cmou_defines.svh"
// splits an address into way and set for index-type operations
module cmou_index_split #(
    parameter int ADDR_W = 32,
    parameter int BYTES_PER_TAG = 32,
    parameter int CACHE_BYTES = 16384,
    parameter int ASSOC = 4
) (
    input wire logic [ADDR_W-1:0] addr,
    output logic [7:0] way,
    output logic [ADDR_W-1:0] index
);
    localparam int LINE_OFFSET_BOUNDARY = $clog2(BYTES_PER_TAG);
    localparam int SET_SELECT_BOUNDARY = $clog2(CACHE_BYTES / ASSOC);
    localparam int WAY_SELECT_BOUNDARY = SET_SELECT_BOUNDARY + $clog2(ASSOC);
    localparam int IDX_W = SET_SELECT_BOUNDARY - LINE_OFFSET_BOUNDARY;

    // set field between offset and set boundaries; see [R5]
    always_comb begin
        index = '0;
        index[IDX_W-1:0] = addr[SET_SELECT_BOUNDARY-1:LINE_OFFSET_BOUNDARY];
    end

    generate
        if (ASSOC > 1) begin : g_assoc
            localparam int WAY_W = WAY_SELECT_BOUNDARY - SET_SELECT_BOUNDARY;
            // way field above the set; see [R5]
            always_comb begin
                way = '0;
                way[WAY_W-1:0] = addr[WAY_SELECT_BOUNDARY-1:SET_SELECT_BOUNDARY];
            end
        end else begin : g_direct
            // direct mapped: way ignored; see [R6]
            assign way = 8'h00;
        end
    endgenerate
endmodule

/* verification/cmou_unit_chk.sv */
// watches the unit's ports for the documented exception and handshake rules
module cmou_unit_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [31:0] insn,
    input wire logic [31:0] base_value,
    input wire logic xlate_req,
    input wire logic [31:0] xlate_vaddr,
    input wire logic xlate_done,
    input wire logic xlate_miss,
    input wire logic xlate_invalid,
    input wire logic [2:0] cacheability_attribute,
    input wire logic cache_req,
    input wire cmou_pkg::cmou_req_s cache_cmd,
    input wire logic cache_ack,
    input wire logic cache_err,
    input wire logic bus_err,
    input wire logic traffic_idle,
    input wire logic retire_valid,
    input wire cmou_pkg::cmou_retire_s retire_info
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] ea;
    logic kern;
    logic [2:0] attr_reg;
    // effective address and faulting kernel region from held inputs
    assign ea = base_value + {{23{insn[15]}}, insn[15:7]};
    assign kern = ea[31:28] == 4'he;
    // attribute as returned with the translation
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            attr_reg <= 3'h0;
        end else if (xlate_done) begin
            attr_reg <= cacheability_attribute;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_xlate_ea;
        $rose(issue_valid) && !kern |=> xlate_req && xlate_vaddr == $past(ea);
    endproperty
    a_xlate_ea: assert property (p_xlate_ea) else $error("translate address wrong");
    property p_cmd_held;
        cache_req && !(cache_ack || cache_err || bus_err) |=> cache_req && $stable(cache_cmd);
    endproperty
    a_cmd_held: assert property (p_cmd_held) else $error("request dropped early");
    property p_global;
        cache_req |-> cache_cmd.global_op ==
            (cache_cmd.oper inside {3'h4, 3'h5, 3'h6} && attr_reg inside {3'h4, 3'h5});
    endproperty
    a_global: assert property (p_global) else $error("broadcast flag wrong");
    property p_causes;
        retire_valid && retire_info.exc |-> retire_info.cause inside
            {5'h02, 5'h1e, 5'h07} || (kern && retire_info.cause == 5'h04);
    endproperty
    a_causes: assert property (p_causes) else $error("forbidden cause");
    property p_xlate_fault;
        xlate_done && (xlate_miss || xlate_invalid) |-> ##[1:8]
            (retire_valid && retire_info.exc && retire_info.cause == 5'h02);
    endproperty
    a_xlate_fault: assert property (p_xlate_fault) else $error("no load fault");
    property p_cache_err;
        cache_req && cache_err && !(insn[20:18] inside {3'h1, 3'h2}) |-> ##[1:20]
            (retire_valid && retire_info.exc && retire_info.cause == 5'h1e);
    endproperty
    a_cache_err: assert property (p_cache_err) else $error("no cache error");
    property p_tag_ops;
        retire_valid && insn[20:18] inside {3'h1, 3'h2} |->
            !(retire_info.exc && retire_info.cause == 5'h1e);
    endproperty
    a_tag_ops: assert property (p_tag_ops) else $error("tag op cache error");
    property p_bus_err;
        cache_req && bus_err |-> ##[1:20]
            (retire_valid && retire_info.exc && retire_info.cause == 5'h07);
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("no bus error");
    property p_retire_idle;
        retire_valid |-> $past(traffic_idle) && !cache_req;
    endproperty
    a_retire_idle: assert property (p_retire_idle) else $error("retire with traffic");
    c_inner: cover property (cache_req && cache_cmd.target == 2'h1 && insn[17]);
    c_global: cover property (cache_req && cache_cmd.global_op);
    c_fault: cover property (retire_valid && retire_info.exc);
endmodule

bind cmou_unit cmou_unit_chk cmou_unit_chk_inst (.*);

/* verification/cmou_far_model.sv */
// mmu and cache controller standing behind the unit
module cmou_far_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic xlate_req,
    input wire logic [31:0] xlate_vaddr,
    input wire logic cache_req,
    input wire logic [1:0] f_fault,
    input wire logic [1:0] f_resp,
    input wire logic [2:0] f_attr,
    input wire logic f_slow,
    output logic xlate_done,
    output logic xlate_miss,
    output logic xlate_invalid,
    output logic [31:0] xlate_paddr,
    output logic [2:0] cacheability_attribute,
    output logic cache_ack,
    output logic cache_err,
    output logic bus_err,
    output logic traffic_idle
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] pa_reg;
    logic [2:0] xcnt_reg;
    logic xbusy_reg;
    logic [1:0] phase_reg;
    logic [2:0] ccnt_reg;
    logic [1:0] idle_reg;
    // translation, mapping flips the top address bit
    always_ff @(posedge sys_clk) begin
        xlate_done <= 1'b0;
        if (rst) begin
            xbusy_reg <= 1'b0;
        end else if (xlate_req) begin
            xbusy_reg <= 1'b1;
            xcnt_reg <= f_slow ? 3'h3 : 3'h0;
            pa_reg <= xlate_vaddr ^ 32'h8000_0000;
        end else if (xbusy_reg && xcnt_reg == 3'h0) begin
            xbusy_reg <= 1'b0;
            xlate_done <= 1'b1;
        end else if (xbusy_reg) begin
            xcnt_reg <= xcnt_reg - 3'h1;
        end
    end
    // results valid with done only, garbage otherwise
    assign xlate_miss = xlate_done & f_fault[0];
    assign xlate_invalid = xlate_done & f_fault[1];
    assign xlate_paddr = xlate_done ? pa_reg : ~pa_reg;
    assign cacheability_attribute = xlate_done ? f_attr : ~f_attr;
    assign traffic_idle = idle_reg == 2'h0;
    // controller answer; ignores the stale request cycle after answering
    always_ff @(posedge sys_clk) begin
        cache_ack <= 1'b0;
        cache_err <= 1'b0;
        bus_err <= 1'b0;
        if (rst) begin
            phase_reg <= 2'h0;
            idle_reg <= 2'h0;
        end else begin
            if (idle_reg != 2'h0) idle_reg <= idle_reg - 2'h1;
            case (phase_reg)
                2'h0: if (cache_req) begin
                    phase_reg <= 2'h1;
                    ccnt_reg <= f_slow ? 3'h4 : 3'h0;
                end
                2'h1: if (ccnt_reg == 3'h0) begin
                    phase_reg <= 2'h2;
                    cache_ack <= f_resp == 2'h0 || f_resp == 2'h3;
                    cache_err <= f_resp == 2'h1;
                    bus_err <= f_resp == 2'h2;
                    idle_reg <= f_slow ? 2'h3 : 2'h1;
                end else begin
                    ccnt_reg <= ccnt_reg - 3'h1;
                end
                default: phase_reg <= 2'h0;
            endcase
        end
    end
endmodule

/* verification/test_cache_maintenance_op_unit.sv */
module test_cache_maintenance_op_unit;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TAG_BYTES = 32;
    localparam int CACHE_SZ = 16384;
    localparam int WAYS = 4;
    localparam int OFS = $clog2(TAG_BYTES);
    localparam int IDB = $clog2(CACHE_SZ / WAYS);
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    logic [31:0] insn = 32'h0000_0000;
    logic [31:0] base_value = 32'h0000_0000;
    logic [1:0] f_fault = 2'h0;
    logic [1:0] f_resp = 2'h0;
    logic [2:0] f_attr = 3'h0;
    logic f_slow = 1'b0;
    logic issue_ready, xlate_req, xlate_done, xlate_miss, xlate_invalid, cache_req;
    logic cache_ack, cache_err, bus_err, traffic_idle, retire_valid;
    logic [31:0] xlate_vaddr, xlate_paddr;
    logic [2:0] cacheability_attribute;
    cmou_pkg::cmou_req_s cache_cmd;
    cmou_pkg::cmou_retire_s retire_info;
    cmou_pkg::cmou_req_s seen[$];
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 28;
    // clock
    always #25 sys_clk = ~sys_clk;
    cmou_unit #(.BYTES_PER_TAG(TAG_BYTES), .CACHE_BYTES(CACHE_SZ), .ASSOC(WAYS)) cmou_unit_inst (.*);
    cmou_far_model cmou_far_model_inst (.*);
    // record each answered command
    always @(posedge sys_clk)
        if (cache_req && (cache_ack || cache_err || bus_err)) seen.push_back(cache_cmd);
    task automatic end_of_test();
        $display("counts: %0d bad of %0d compares", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic note(input logic ok, input logic [79:0] e, input logic [79:0] g);
        cmp_count++;
        if (!ok) begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_cmd(input cmou_pkg::cmou_req_s e, input cmou_pkg::cmou_req_s g);
        note(g === e, 80'(e), 80'(g));
    endtask
    task automatic cmp_ret(input cmou_pkg::cmou_retire_s e, input cmou_pkg::cmou_retire_s g);
        note(g === e, 80'(e), 80'(g));
    endtask
    task automatic cmp_num(input logic [3:0] e, input logic [3:0] g);
        note(g === e, 80'(e), 80'(g));
    endtask
    function automatic logic [31:0] mk(input logic [2:0] op, input logic [1:0] tg,
                                       input logic [8:0] off);
        return {11'h000, op, tg, off, 7'h00};
    endfunction
    // random base outside the faulting kernel region
    function automatic logic [31:0] rb();
        return 32'($random(seed)) & 32'h7fff_ffff;
    endfunction
    // one instruction, then its expected commands and retirement
    task automatic run_op(input logic [31:0] ins, input logic [31:0] bv,
                          input logic [1:0] flt, input logic [1:0] rsp);
        cmou_pkg::cmou_retire_s got, ex;
        cmou_pkg::cmou_req_s ec;
        logic [31:0] ea;
        logic [2:0] op;
        logic [1:0] tg;
        logic kern;
        int n;
        ea = bv + {{23{ins[15]}}, ins[15:7]};
        op = ins[20:18];
        tg = ins[17:16];
        kern = ea[31:28] == 4'he;
        got = '0;
        seen.delete();
        @(negedge sys_clk);
        insn = ins;
        base_value = bv;
        f_fault = flt;
        f_resp = rsp;
        f_attr = 3'($random(seed));
        f_slow = 1'($random(seed));
        issue_valid = 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
            if (retire_valid === 1'b1) got = retire_info;
        end while (issue_ready !== 1'b1 && n < 200);
        issue_valid = 1'b0;
        if (n >= 200) begin
            bad_count++;
            end_of_test();
        end
        ex = '0;
        if (kern) ex = {1'b1, 5'h04};
        else if (flt != 2'h0) ex = {1'b1, 5'h02};
        else if (rsp == 2'h1 && !(op inside {3'h1, 3'h2})) ex = {1'b1, 5'h1e};
        else if (rsp == 2'h2) ex = {1'b1, 5'h07};
        if (!ex.exc) got.cause = 5'h00;
        cmp_ret(ex, got);
        cmp_num((kern || flt != 2'h0) ? 4'h0 : (tg[1] ? 4'h2 : 4'h1), 4'(seen.size()));
        foreach (seen[i]) begin
            ec.target = (tg[1] && i == 0) ? 2'h1 : tg;
            ec.oper = op;
            ec.addr = op[2] ? (ea ^ 32'h8000_0000) : ea;
            ec.way = 8'((ec.addr >> IDB) & 32'(WAYS - 1));
            ec.index = (ec.addr >> OFS) & ((32'h1 << (IDB - OFS)) - 32'h1);
            ec.global_op = op[2] && op != 3'h7 && f_attr[2:1] == 2'b10;
            cmp_cmd(ec, seen[i]);
        end
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        for (int k = 0; k < 32; k++) run_op(mk(3'(k), 2'(k >> 3), 9'($random(seed))), rb(), 2'h0, 2'h0);
        run_op(mk(3'h5, 2'h1, 9'h100), 32'h0000_0103, 2'h0, 2'h0);
        run_op(mk(3'h0, 2'h1, 9'h0ff), 32'h0000_3fe1, 2'h0, 2'h0);
        run_op(mk(3'h4, 2'h1, 9'h1ff), rb(), 2'h1, 2'h0);
        run_op(mk(3'h5, 2'h3, 9'h001), rb(), 2'h2, 2'h0);
        run_op(mk(3'h6, 2'h1, 9'h000), 32'he000_0040, 2'h0, 2'h0);
        run_op(mk(3'h5, 2'h1, 9'h020), rb(), 2'h0, 2'h1);
        run_op(mk(3'h1, 2'h0, 9'h020), rb(), 2'h0, 2'h1);
        run_op(mk(3'h2, 2'h1, 9'h020), rb(), 2'h0, 2'h1);
        run_op(mk(3'h6, 2'h0, 9'h020), rb(), 2'h0, 2'h2);
        for (int k = 0; k < 40; k++) begin
            insn = mk(3'($random(seed)), 2'($random(seed)), 9'($random(seed)));
            run_op(insn, rb(), 2'($random(seed)) & 2'($random(seed)),
                   insn[17] ? 2'h0 : 2'($random(seed)));
        end
        end_of_test();
    end
endmodule
